// *** testbench/ica_host_model.sv ***
// Host bus model that issues indexed register writes and reads.
module ica_host_model (
   input wire logic ref_clk,         // Host bus clock.
   output logic [7:0] regIndex,      // Register index.
   output logic regWrite,            // Write strobe.
   output logic regRead,             // Read strobe.
   output logic [7:0] regWrData,     // Write data.
   input wire logic [7:0] regRdData  // Read data.
);
   timeunit 1ns;
   timeprecision 100ps;
   // The bus starts idle with both strobes low.
   initial begin
      regIndex = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWrData = 8'hFF;
   end
   // One-cycle write; the data lines show the inverse once released.
   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      @(negedge ref_clk);
      regIndex = idx;
      regWrData = data;
      regWrite = 1'b1;
      @(negedge ref_clk);
      regWrite = 1'b0;
      regIndex = ~idx;
      regWrData = ~data;
   endtask
   // One-cycle read; the data is taken once the registered answer has landed.
   task automatic rd(input logic [7:0] idx, output logic [7:0] data);
      @(negedge ref_clk);
      regIndex = idx;
      regRead = 1'b1;
      @(negedge ref_clk);
      regRead = 1'b0;
      regIndex = ~idx;
      @(negedge ref_clk);
      data = regRdData;
   endtask
endmodule

// *** testbench/icon_control_and_aperture_regs_test.sv ***
// Self-checking bench for the icon control and aperture register bank.
module icon_control_and_aperture_regs_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0, nrst = 1'b0, cursorBlinkTick = 1'b0, pciMode = 1'b1;
   logic regWrite, regRead;
   logic [7:0] regIndex, regWrData, regRdData, pciAddrTop = 8'h00;
   logic [7:0] base10Top = 8'h00, base14Top = 8'h00;
   logic [5:0] iconPixel = 6'h3F;
   logic [3:0] segmentSelect = 4'h0, hostAddrHigh = 4'h0;
   logic [1:0] upperAddressMatchPins = 2'h0;
   logic [31:0] hostData = 32'h1122_3344, swapData;
   logic [2:0] iconShow, iconTransparentMode, iconMapSel, iconVDouble, iconHDouble;
   logic [2:0] iconBlinkPhase;
   logic [2:0][7:0] iconHeight, iconWidth, iconPushDown;
   logic localClaim, upperMatch, linearMode, pciBaseMapped, base10Hit, base14Hit;
   logic [7:0] idx [3] = '{ica_pkg::IDX_ICON1, ica_pkg::IDX_ICON2, ica_pkg::IDX_ICON3};
   int bad_count = 0;
   int check_count = 0;
   // Clock at 50 ns period.
   always #25 ref_clk = ~ref_clk;
   ica_host_model i_host (.ref_clk, .regIndex, .regWrite, .regRead, .regWrData, .regRdData);
   ica_regs i_dut (.ref_clk, .nrst, .regIndex, .regWrite, .regRead, .regWrData, .regRdData,
      .cursorBlinkTick, .iconPixel, .pciMode, .segmentSelect, .upperAddressMatchPins,
      .hostAddrHigh, .pciAddrTop, .base10Top, .base14Top, .hostData, .iconShow,
      .iconTransparentMode, .iconMapSel, .iconVDouble, .iconHDouble, .iconHeight, .iconWidth,
      .iconPushDown, .iconBlinkPhase, .localClaim, .upperMatch, .linearMode, .pciBaseMapped,
      .base10Hit, .base14Hit, .swapData);
   // ****************************************
   // Shared checking tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Reads a register and compares it.
   task automatic chk_reg(input logic [7:0] id, input logic [7:0] exp);
      logic [7:0] got;
      i_host.rd(id, got);
      chk("regRdData", {24'h00_0000, exp}, {24'h00_0000, got});
   endtask
   // Lets the registered outputs follow inputs changed at the last falling edge.
   task automatic settle();
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Watchdog that cuts a hung run short.
   initial begin
      #1000000;
      bad_count++;
      end_sim();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (10) @(negedge ref_clk);
      nrst = 1'b1;
      foreach (idx[i]) chk_reg(idx[i], 8'h00);
      settle();
      chk("iconShow", 3'h0, iconShow);
      chk("base14Hit", 1'b0, base14Hit);
      i_host.wr(8'h2E, 8'hFF);
      i_host.wr(8'h2A, 8'hFF);
      chk_reg(8'h2E, 8'h00);
      chk_reg(8'h2B, 8'h00);
      // Every field but blink of each icon, then transparency and enable.
      for (int i = 0; i < 3; i++) begin
         i_host.wr(idx[i], 8'h3B);
         chk_reg(idx[i], 8'h3B);
         settle();
         chk("iconShow", 3'h1 << i, iconShow);
         chk("iconTransparentMode", 3'h1 << i, iconTransparentMode);
         chk("iconMapSel", 3'h1 << i, iconMapSel);
         chk("iconVDouble", 3'h1 << i, iconVDouble);
         chk("iconHDouble", 3'h1 << i, iconHDouble);
         chk("iconHeight", 8'h80, iconHeight[i]);
         chk("iconWidth", 8'h80, iconWidth[i]);
         chk("iconPushDown", 24'h40_4040 & ~(24'hFF << 8 * i), iconPushDown);
         iconPixel = 6'h15;
         settle();
         chk("iconShow", 3'h1 << i, iconShow);
         iconPixel = 6'h00;
         settle();
         chk("iconShow", 3'h0, iconShow);
         i_host.wr(idx[i], 8'h39);
         settle();
         chk("iconShow", 3'h1 << i, iconShow);
         i_host.wr(idx[i], 8'h38);
         settle();
         chk("iconShow", 3'h0, iconShow);
         iconPixel = 6'h3F;
         i_host.wr(idx[i], 8'h00);
      end
      i_host.wr(8'h2B, 8'h10);
      i_host.wr(8'h2C, 8'h10);
      settle();
      chk("iconPushDown", 24'h80_4040, iconPushDown);
      i_host.wr(8'h2C, 8'h00);
      // Blink toggles every second cursor tick, starting visible.
      i_host.wr(8'h2B, 8'h15);
      settle();
      chk("iconBlinkPhase", 3'h7, iconBlinkPhase);
      for (int k = 1; k <= 3; k++) begin
         cursorBlinkTick = 1'b1;
         @(negedge ref_clk);
         cursorBlinkTick = 1'b0;
         settle();
         chk("iconBlinkPhase", {2'b11, (k % 4) < 2}, iconBlinkPhase);
      end
      chk("iconShow", 3'h0, iconShow);
      i_host.wr(8'h2B, 8'h01);
      settle();
      chk("iconBlinkPhase", 3'h7, iconBlinkPhase);
      chk("iconShow", 3'h1, iconShow);
      // Local bus claim against the reference field and segment bits.
      pciMode = 1'b0;
      i_host.wr(8'h2D, 8'h80);
      segmentSelect = 4'hA;
      hostAddrHigh = 4'hA;
      upperAddressMatchPins = 2'h2;
      settle();
      chk("upperMatch", 1'b1, upperMatch);
      chk("localClaim", 1'b1, localClaim);
      hostAddrHigh = 4'h5;
      settle();
      chk("localClaim", 1'b0, localClaim);
      hostAddrHigh = 4'hA;
      upperAddressMatchPins = 2'h1;
      settle();
      chk("upperMatch", 1'b0, upperMatch);
      chk("localClaim", 1'b0, localClaim);
      // PCI linear mode and base register mapping.
      pciMode = 1'b1;
      upperAddressMatchPins = 2'h2;
      base10Top = 8'h12;
      pciAddrTop = 8'h12;
      settle();
      chk("localClaim", 1'b0, localClaim);
      chk("linearMode", 1'b1, linearMode);
      chk("pciBaseMapped", 1'b1, pciBaseMapped);
      chk("base10Hit", 1'b1, base10Hit);
      i_host.wr(8'h2D, 8'h00);
      settle();
      chk("linearMode", 1'b0, linearMode);
      chk("pciBaseMapped", 1'b1, pciBaseMapped);
      segmentSelect = 4'h0;
      settle();
      chk("pciBaseMapped", 1'b0, pciBaseMapped);
      chk("base10Hit", 1'b0, base10Hit);
      // Second base range enable and byte swap.
      base14Top = 8'h34;
      pciAddrTop = 8'h34;
      i_host.wr(8'h2C, 8'h40);
      settle();
      chk("base14Hit", 1'b0, base14Hit);
      chk("swapData", 32'h1122_3344, swapData);
      i_host.wr(8'h2C, 8'hC0);
      settle();
      chk("base14Hit", 1'b1, base14Hit);
      chk("swapData", 32'h2211_4433, swapData);
      pciAddrTop = 8'h35;
      settle();
      chk("swapData", 32'h1122_3344, swapData);
      pciAddrTop = 8'h34;
      pciMode = 1'b0;
      settle();
      chk("base14Hit", 1'b0, base14Hit);
      end_sim();
   end
endmodule

// *** verilog/ica_pkg.sv ***
// Constants shared by the icon control and aperture register bank.
package ica_pkg;
   // ****************************************
   // Register indexes on the indexed data port
   // ****************************************
   localparam logic [7:0] IDX_ICON1 = 8'h2B;
   localparam logic [7:0] IDX_ICON2 = 8'h2C;
   localparam logic [7:0] IDX_ICON3 = 8'h2D;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // ****************************************
   // Field positions shared by the three icon control registers
   // ****************************************
   localparam int BIT_ENABLE = 0;
   localparam int BIT_MODE = 1;
   localparam int BIT_BLINK = 2;
   localparam int BIT_HDOUBLE = 3;
   localparam int BIT_VDOUBLE = 4;
   localparam int BIT_MAPSEL = 5;
   // ****************************************
   // Fields of the upper two bits of the icon 2 and icon 3 registers
   // ****************************************
   localparam int BIT_BYTESWAP = 6;
   localparam int BIT_BASE14EN = 7;
   localparam int UPPER_REF_LSB = 6;
   localparam int UPPER_REF_MSB = 7;
   // ****************************************
   // Icon geometry and pixel coding
   // ****************************************
   localparam logic [7:0] ICON_SIZE = 8'h40;
   localparam logic [7:0] ICON_SIZE_DOUBLED = 8'h80;
   localparam logic [1:0] TRANSPARENT_CODE = 2'h0;
   localparam int NUM_ICONS = 3;
endpackage

// *** verilog/ica_regs.sv ***
// Icon control and aperture register bank with overlay and decode outputs.

// What this block does
// - Blink bit toggles icon at half cursor rate.
// - Icon pixels are always two-bit codes.
// - Mode bit picks four colours or transparent.
// - Icon shows only while enable bit set.
// - Map-select bit picks display memory map.
// - Vertical doubling gives 128 icon scanlines.
// - Doubled icon grows down, pushing others down.
// - Horizontal doubling gives 128 pixels rightward.
// - Second-base enable gates upper-byte range decode.
// - Byte swap exchanges bytes in that range.
// - Reference field compared with upper address pins.
// - Local bus claim needs pins and segment match.
// - In PCI mode, nonzero reference field means linear memory mode.
// - In PCI mode, nonzero reference or segment uses base registers.
module ica_regs (
   input wire logic ref_clk,                     // Host bus clock.
   input wire logic nrst,                        // Asynchronous reset, active low.
   input wire logic [7:0] regIndex,              // Index of the addressed register.
   input wire logic regWrite,                    // Write strobe for the data port.
   input wire logic regRead,                     // Read strobe for the data port.
   input wire logic [7:0] regWrData,             // Write data.
   output logic [7:0] regRdData,                 // Read data, held until next read.
   input wire logic cursorBlinkTick,             // Pulse at each text-cursor toggle.
   input wire logic [5:0] iconPixel,             // Two-bit pixel codes, icon 1 lowest.
   input wire logic pciMode,                     // High when the host bus is PCI.
   input wire logic [3:0] segmentSelect,         // Segment select bits from elsewhere.
   input wire logic [1:0] upperAddressMatchPins, // Upper address pins.
   input wire logic [3:0] hostAddrHigh,          // Host address bits 23 to 20.
   input wire logic [7:0] pciAddrTop,            // PCI address bits 31 to 24.
   input wire logic [7:0] base10Top,             // Upper byte of base register 10h.
   input wire logic [7:0] base14Top,             // Upper byte of base register 14h.
   input wire logic [31:0] hostData,             // Host data word.
   output logic [2:0] iconShow,                  // Icon pixel drawn this cycle.
   output logic [2:0] iconTransparentMode,       // Three colours plus transparent.
   output logic [2:0] iconMapSel,                // Selected display memory map.
   output logic [2:0] iconVDouble,               // Vertical doubling active.
   output logic [2:0] iconHDouble,               // Horizontal doubling active.
   output logic [2:0][7:0] iconHeight,           // Displayed scanlines per icon.
   output logic [2:0][7:0] iconWidth,            // Displayed pixels per icon.
   output logic [2:0][7:0] iconPushDown,         // Extra lines each icon is moved down.
   output logic [2:0] iconBlinkPhase,            // Visibility of each icon's blink.
   output logic localClaim,                      // Local bus cycle claimed.
   output logic upperMatch,                      // Reference field matches pins.
   output logic linearMode,                      // PCI linear memory mode.
   output logic pciBaseMapped,                   // PCI map follows base registers.
   output logic base10Hit,                       // PCI address in base 10h range.
   output logic base14Hit,                       // PCI address in base 14h range.
   output logic [31:0] swapData                  // Host data, swapped when required.
);
   // ****************************************
   // Index decode
   // ****************************************
   // Maps an index to a register slot, or to three when unmapped.
   function automatic logic [1:0] slotOf(input logic [7:0] idx);
      case (idx)
         ica_pkg::IDX_ICON1: slotOf = 2'h0;
         ica_pkg::IDX_ICON2: slotOf = 2'h1;
         ica_pkg::IDX_ICON3: slotOf = 2'h2;
         default: slotOf = 2'h3;
      endcase
   endfunction

   // ****************************************
   // Register storage and read port
   // ****************************************
   logic [2:0][7:0] ctrl;
   logic [2:0][7:0] next_ctrl;
   logic [7:0] next_regRdData;
   // Writes land in the decoded slot; unmapped writes are dropped, reads return zero.
   always_comb begin
      next_ctrl = ctrl;
      next_regRdData = regRdData;
      if (regWrite && slotOf(regIndex) != 2'h3) begin
         next_ctrl[slotOf(regIndex)] = regWrData;
      end
      if (regRead) begin
         if (slotOf(regIndex) != 2'h3) begin
            next_regRdData = ctrl[slotOf(regIndex)];
         end else begin
            next_regRdData = ica_pkg::UNMAPPED_READ;
         end
      end
   end

   // Registers the bank; everything clears on reset.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= '{default: ica_pkg::REG_RESET};
         regRdData <= ica_pkg::REG_RESET;
      end else begin
         ctrl <= next_ctrl;
         regRdData <= next_regRdData;
      end
   end

   // ****************************************
   // Blink divider
   // ****************************************
   logic blinkHalf;
   logic next_blinkHalf;
   logic blinkVisible;
   logic next_blinkVisible;
   // Visibility flips on every second cursor toggle, half the cursor rate.
   always_comb begin
      next_blinkHalf = blinkHalf;
      next_blinkVisible = blinkVisible;
      if (cursorBlinkTick) begin
         next_blinkHalf = !blinkHalf;
         if (blinkHalf) begin
            next_blinkVisible = !blinkVisible;
         end
      end
   end

   // Registers the blink divider.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         blinkHalf <= 1'b0;
         blinkVisible <= 1'b1;
      end else begin
         blinkHalf <= next_blinkHalf;
         blinkVisible <= next_blinkVisible;
      end
   end

   // ****************************************
   // Per-icon overlay controls
   // ****************************************
   logic [2:0] vdbl;
   logic [2:0] next_iconShow;
   logic [2:0] next_iconBlinkPhase;
   logic [2:0][7:0] next_iconHeight;
   logic [2:0][7:0] next_iconWidth;
   logic [2:0][7:0] next_iconPushDown;
   generate
      for (genvar i = 0; i < ica_pkg::NUM_ICONS; i++) begin : g_icon
         assign vdbl[i] = ctrl[i][ica_pkg::BIT_VDOUBLE];
         // Steady icons stay visible; blinking icons follow the divider.
         assign next_iconBlinkPhase[i] =
            !ctrl[i][ica_pkg::BIT_BLINK] || blinkVisible;
         // The pixel code is always two bits wide, and code zero is
         // see-through only in the transparent mode.
         assign next_iconShow[i] = ctrl[i][ica_pkg::BIT_ENABLE]
            && next_iconBlinkPhase[i]
            && !(ctrl[i][ica_pkg::BIT_MODE]
               && iconPixel[2*i +: 2] == ica_pkg::TRANSPARENT_CODE);
         // Doubling sets the height and width to twice the base icon size.
         assign next_iconHeight[i] = vdbl[i] ? ica_pkg::ICON_SIZE_DOUBLED
            : ica_pkg::ICON_SIZE;
         assign next_iconWidth[i] = ctrl[i][ica_pkg::BIT_HDOUBLE]
            ? ica_pkg::ICON_SIZE_DOUBLED : ica_pkg::ICON_SIZE;
      end
   endgenerate
   // Each icon moves down by one icon height for every other doubled icon.
   always_comb begin
      for (int i = 0; i < ica_pkg::NUM_ICONS; i++) begin
         next_iconPushDown[i] = '0;
         for (int j = 0; j < ica_pkg::NUM_ICONS; j++) begin
            if (j != i && vdbl[j]) begin
               next_iconPushDown[i] = 8'(next_iconPushDown[i] + ica_pkg::ICON_SIZE);
            end
         end
      end
   end

   // Registers the overlay controls.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         iconShow <= '0;
         iconTransparentMode <= '0;
         iconMapSel <= '0;
         iconVDouble <= '0;
         iconHDouble <= '0;
         iconHeight <= '{default: ica_pkg::ICON_SIZE};
         iconWidth <= '{default: ica_pkg::ICON_SIZE};
         iconPushDown <= '0;
         iconBlinkPhase <= '1;
      end else begin
         iconShow <= next_iconShow;
         for (int i = 0; i < ica_pkg::NUM_ICONS; i++) begin
            iconTransparentMode[i] <= ctrl[i][ica_pkg::BIT_MODE];
            iconMapSel[i] <= ctrl[i][ica_pkg::BIT_MAPSEL];
            iconHDouble[i] <= ctrl[i][ica_pkg::BIT_HDOUBLE];
         end
         iconVDouble <= vdbl;
         iconHeight <= next_iconHeight;
         iconWidth <= next_iconWidth;
         iconPushDown <= next_iconPushDown;
         iconBlinkPhase <= next_iconBlinkPhase;
      end
   end

   // ****************************************
   // Host address decode
   // ****************************************
   logic [1:0] upperRef;
   logic base14En;
   logic swapEn;
   logic next_upperMatch;
   logic next_localClaim;
   logic next_linearMode;
   logic next_pciBaseMapped;
   logic next_base10Hit;
   logic next_base14Hit;
   logic [31:0] next_swapData;
   assign upperRef = ctrl[2][ica_pkg::UPPER_REF_MSB:ica_pkg::UPPER_REF_LSB];
   assign base14En = ctrl[1][ica_pkg::BIT_BASE14EN];
   assign swapEn = ctrl[1][ica_pkg::BIT_BYTESWAP];
   // Upper range compare, local claim, PCI map selection and byte lane swap.
   // A nonzero reference field breaks segmented addressing, so software keeps it zero there.
   always_comb begin
      next_upperMatch = upperRef == upperAddressMatchPins;
      next_localClaim = !pciMode && next_upperMatch
         && hostAddrHigh == segmentSelect;
      next_linearMode = pciMode && upperRef != 2'h0;
      next_pciBaseMapped = pciMode && (upperRef != 2'h0 || segmentSelect != 4'h0);
      next_base10Hit = next_pciBaseMapped && pciAddrTop == base10Top;
      next_base14Hit = pciMode && base14En && pciAddrTop == base14Top;
      next_swapData = hostData;
      if (next_base14Hit && swapEn) begin
         next_swapData = {hostData[23:16], hostData[31:24],
            hostData[7:0], hostData[15:8]};
      end
   end

   // Registers the decode results.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         upperMatch <= 1'b0;
         localClaim <= 1'b0;
         linearMode <= 1'b0;
         pciBaseMapped <= 1'b0;
         base10Hit <= 1'b0;
         base14Hit <= 1'b0;
         swapData <= 32'h0000_0000;
      end else begin
         upperMatch <= next_upperMatch;
         localClaim <= next_localClaim;
         linearMode <= next_linearMode;
         pciBaseMapped <= next_pciBaseMapped;
         base10Hit <= next_base10Hit;
         base14Hit <= next_base14Hit;
         swapData <= next_swapData;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // A cursor toggle that only advances the divider, not the visibility.
   sequence s_odd_tick;
      cursorBlinkTick && !blinkHalf;
   endsequence
   AST_BLINK_STEADY: assert property (
      !ctrl[0][ica_pkg::BIT_BLINK] |=> iconBlinkPhase[0])
      else $error("Steady icon lost visibility.");
   AST_BLINK_HALF: assert property (
      s_odd_tick |=> $stable(blinkVisible))
      else $error("Icon blink toggled on an odd cursor tick.");
   AST_ENABLE: assert property (
      !ctrl[1][ica_pkg::BIT_ENABLE] |=> !iconShow[1])
      else $error("Disabled icon produced a pixel.");
   AST_TRANSPARENT: assert property (
      (ctrl[0][ica_pkg::BIT_MODE] && iconPixel[1:0] == ica_pkg::TRANSPARENT_CODE)
      |=> !iconShow[0])
      else $error("Transparent code was drawn.");
   AST_MAPSEL: assert property (
      ##1 iconMapSel[2] == $past(ctrl[2][ica_pkg::BIT_MAPSEL]))
      else $error("Map select does not follow its bit.");
   AST_VDOUBLE: assert property (
      vdbl[0] |=> iconHeight[0] == ica_pkg::ICON_SIZE_DOUBLED)
      else $error("Doubled icon height is not 128.");
   AST_PUSHDOWN: assert property (
      (vdbl == 3'b001) |=> iconPushDown == {ica_pkg::ICON_SIZE, ica_pkg::ICON_SIZE, 8'h00})
      else $error("Other icon was not pushed down.");
   AST_HDOUBLE: assert property (
      ctrl[1][ica_pkg::BIT_HDOUBLE] |=> iconWidth[1] == ica_pkg::ICON_SIZE_DOUBLED)
      else $error("Doubled icon width is not 128.");
   AST_BASE14: assert property (
      !base14En |=> !base14Hit)
      else $error("Base 14h range decoded while disabled.");
   AST_SWAP: assert property (
      (pciMode && base14En && swapEn && pciAddrTop == base14Top)
      |=> swapData[15:8] == $past(hostData[7:0]) && swapData[31:24] == $past(hostData[23:16]))
      else $error("Byte lanes were not swapped.");
   AST_CLAIM: assert property (
      (pciMode || !next_upperMatch) |=> !localClaim)
      else $error("Local claim without upper address match.");
   AST_LINEAR: assert property (
      (pciMode && upperRef != 2'h0) |=> linearMode && pciBaseMapped)
      else $error("Linear mode not entered.");
endmodule
